/* hdl/adcsq_map.svh */
// constants of the converter sequencer: widths, fields, reset values, counts
`ifndef ADCSQ_MAP_SVH
`define ADCSQ_MAP_SVH
`define ADCSQ_RES_W      10
`define ADCSQ_CHN_W      4
`define ADCSQ_P5_CHANS   16
`define ADCSQ_P1_CHANS   8
`define ADCSQ_PIN_W      24
`define ADCSQ_REG_W      16
`define ADCSQ_RES_LSB    0
`define ADCSQ_CHN_LSB    12
`define ADCSQ_REG_RST    16'h0000
`define ADCSQ_CAL_CYCLES 40630
`define ADCSQ_CAL_W      16
`define ADCSQ_SAR_STEPS  4'hA
`define ADCSQ_TMR_W      8
`define ADCSQ_FIFO_DEPTH 4
`endif

/* hdl/adcsq_pkg.sv */
// types shared by the converter sequencer modules
package adcsq_pkg;
  typedef enum logic [1:0] {
    MODE_SINGLE      = 2'h0,
    MODE_CONT        = 2'h1,
    MODE_SCAN_SINGLE = 2'h2,
    MODE_SCAN_CONT   = 2'h3
  } adcsq_mode_e;
  typedef enum logic [5:0] {
    ST_CAL  = 6'b00_0001,
    ST_IDLE = 6'b00_0010,
    ST_SAMP = 6'b00_0100,
    ST_CONV = 6'b00_1000,
    ST_DONE = 6'b01_0000,
    ST_GAP  = 6'b10_0000
  } adcsq_state_e;
endpackage

/* hdl/adcsq_stream_if.sv */
// valid/ready word stream between sequencer and its result fifo
`timescale 1ns/100ps
interface adcsq_stream_if #(parameter int W = 14);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

/* hdl/adcsq_fifo.sv */
// small flip-flop fifo with valid/ready on both sides
`timescale 1ns/100ps
module adcsq_fifo #(
  parameter int WIDTH = 14,
  parameter int DEPTH = 4
) (
  input  wire logic   clock,
  input  wire logic   rst_n,
  adcsq_stream_if.snk wr,
  adcsq_stream_if.src rd
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wp_q;
  logic [AW-1:0]    rp_q;
  logic [AW:0]      cnt_q;
  logic             push;
  logic             pop;

  assign wr.ready = (cnt_q != (AW+1)'(DEPTH));
  assign rd.valid = (cnt_q != '0);
  assign rd.data  = mem_q[rp_q];
  assign push     = wr.valid && wr.ready;
  assign pop      = rd.valid && rd.ready;

  always_ff @(posedge clock) begin
    if (push) begin
      mem_q[wp_q] <= wr.data;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wp_q <= (wp_q == AW'(DEPTH-1)) ? '0 : wp_q + 1'b1;
      end
      if (pop) begin
        rp_q <= (rp_q == AW'(DEPTH-1)) ? '0 : rp_q + 1'b1;
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule

/* hdl/adcsq_ctrl.sv */
// sequencer and result logic of the 10-bit multiplexed converter
`timescale 1ns/100ps
`include "adcsq_map.svh"
module adcsq_ctrl #(
  parameter int CAL_CYCLES = `ADCSQ_CAL_CYCLES,
  parameter int FIFO_DEPTH = `ADCSQ_FIFO_DEPTH
) (
  input  wire logic                        clock,
  input  wire logic                        reset_n,
  input  wire logic                        start,
  input  wire logic                        stop,
  input  wire adcsq_pkg::adcsq_mode_e      mode,
  input  wire logic [`ADCSQ_CHN_W-1:0]     chan_sel,
  input  wire logic                        port_grp_sel,
  input  wire logic                        hold_until_read_bit,
  input  wire logic [`ADCSQ_TMR_W-1:0]     sample_time,
  input  wire logic [`ADCSQ_TMR_W-1:0]     conv_time,
  input  wire logic                        inject_req,
  input  wire logic [`ADCSQ_CHN_W-1:0]     inject_chan,
  input  wire logic                        result_rd,
  input  wire logic [`ADCSQ_RES_W-1:0]     ana_data,
  input  wire logic [`ADCSQ_PIN_W-1:0]     ana_pins,
  output logic [`ADCSQ_REG_W-1:0]          conv_result_reg,
  output logic [`ADCSQ_REG_W-1:0]          inject_result_reg,
  output logic                             calib_busy_flag,
  output logic                             conv_busy,
  output logic                             result_unread,
  output logic                             conv_done_req,
  output logic                             overrun_irq,
  output logic                             inject_done,
  output logic                             sample_en,
  output logic [`ADCSQ_CHN_W-1:0]          mux_chan,
  output logic                             mux_grp,
  output logic [`ADCSQ_PIN_W-1:0]          dig_pins
);
  import adcsq_pkg::*;

  localparam int DW = `ADCSQ_CHN_W + `ADCSQ_RES_W;

  logic [1:0]                 rst_s_q;
  logic                       rst_n_i;
  adcsq_state_e               state_q;
  logic [`ADCSQ_CAL_W-1:0]    cal_cnt_q;
  logic [`ADCSQ_TMR_W-1:0]    tmr_q;
  logic [3:0]                 step_q;
  logic [`ADCSQ_CHN_W-1:0]    cur_chan_q;
  logic [`ADCSQ_RES_W-1:0]    res_q;
  logic                       inj_q;
  logic                       inj_pend_q;
  logic                       stop_pend_q;
  logic                       seq_end_q;
  logic                       unread_q;
  logic [`ADCSQ_PIN_W-1:0]    pin_s1_q;
  logic [`ADCSQ_PIN_W-1:0]    pin_s2_q;
  logic [`ADCSQ_PIN_W-1:0]    pin_s3_q;
  logic                       cal_end;
  logic                       samp_end;
  logic                       conv_end;
  logic                       push;
  logic                       pop;
  logic                       gate_ok;
  logic                       hold_act;
  logic                       last_chan;
  logic [`ADCSQ_CHN_W-1:0]    sel_chan;

  adcsq_stream_if #(.W(DW)) fin ();
  adcsq_stream_if #(.W(DW)) fout ();

  // two-stage release keeps reset removal clean against the clock
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rst_s_q <= 2'h0;
    end else begin
      rst_s_q <= {rst_s_q[0], 1'b1};
    end
  end
  assign rst_n_i = rst_s_q[1];

  assign cal_end   = (cal_cnt_q == `ADCSQ_CAL_W'(CAL_CYCLES - 1));
  assign samp_end  = (tmr_q == '0);
  assign conv_end  = (tmr_q == '0) && (step_q == 4'h0);
  assign hold_act  = hold_until_read_bit && mode[0];
  assign push      = fin.valid && fin.ready;
  assign pop       = fout.valid && fout.ready;
  assign last_chan = (cur_chan_q == '0);
  // hold mode: next conversion waits until buffered result is taken
  assign gate_ok   = !hold_act || (!unread_q && !fout.valid);
  // second group has only 8 inputs, upper index bit is dropped
  assign sel_chan  = inj_q ? inject_chan : cur_chan_q;

  assign fin.valid  = (state_q == ST_DONE) && !inj_q;
  assign fin.data   = {cur_chan_q, res_q};
  // hold applies to continuous runs only; other modes report overrun instead
  assign fout.ready = !hold_act || !unread_q;

  adcsq_fifo #(
    .WIDTH (DW),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clock (clock),
    .rst_n (rst_n_i),
    .wr    (fin),
    .rd    (fout)
  );

  // calibration counter runs once after every reset
  always_ff @(posedge clock or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cal_cnt_q <= '0;
    end else if (state_q == ST_CAL && !cal_end) begin
      cal_cnt_q <= cal_cnt_q + 1'b1;
    end
  end

  // main sequence
  always_ff @(posedge clock or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q <= ST_CAL;
    end else begin
      case (state_q)
        ST_CAL: begin
          // start is not looked at here, so it leaves no trace
          if (cal_end) begin
            state_q <= ST_IDLE;
          end
        end
        ST_IDLE: begin
          if (start) begin
            state_q <= ST_SAMP;
          end
        end
        ST_SAMP: begin
          if (samp_end) begin
            state_q <= ST_CONV;
          end
        end
        ST_CONV: begin
          if (conv_end) begin
            state_q <= ST_DONE;
          end
        end
        ST_DONE: begin
          if (inj_q || push) begin
            state_q <= ST_GAP;
          end
        end
        ST_GAP: begin
          if (stop_pend_q || seq_end_q) begin
            state_q <= ST_IDLE;
          end else if (gate_ok) begin
            state_q <= ST_SAMP;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // sample and conversion timing from software-set durations
  always_ff @(posedge clock or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tmr_q  <= '0;
      step_q <= 4'h0;
    end else begin
      case (state_q)
        ST_IDLE, ST_GAP: begin
          tmr_q <= sample_time;
        end
        ST_SAMP: begin
          if (samp_end) begin
            tmr_q  <= conv_time;
            step_q <= `ADCSQ_SAR_STEPS - 4'h1;
          end else begin
            tmr_q <= tmr_q - 1'b1;
          end
        end
        ST_CONV: begin
          if (tmr_q == '0) begin
            tmr_q  <= conv_time;
            step_q <= (step_q == 4'h0) ? 4'h0 : step_q - 4'h1;
          end else begin
            tmr_q <= tmr_q - 1'b1;
          end
        end
        default: begin
          tmr_q <= tmr_q;
        end
      endcase
    end
  end

  // channel walk; scan counts down from the selected channel to zero
  always_ff @(posedge clock or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cur_chan_q <= '0;
      seq_end_q  <= 1'b0;
    end else if (state_q == ST_IDLE && start) begin
      cur_chan_q <= chan_sel;
      seq_end_q  <= 1'b0;
    end else if (push) begin
      seq_end_q <= !mode[0] && (!mode[1] || last_chan);
      if (mode[1]) begin
        cur_chan_q <= last_chan ? chan_sel : cur_chan_q - 1'b1;
      end
    end
  end

  // capture of the converted value
  always_ff @(posedge clock or negedge rst_n_i) begin
    if (!rst_n_i) begin
      res_q <= '0;
    end else if (state_q == ST_CONV && conv_end) begin
      res_q <= ana_data;
    end
  end

  // injection requests taken only while a continuous run is active; stop requests during any run
  always_ff @(posedge clock or negedge rst_n_i) begin
    if (!rst_n_i) begin
      inj_pend_q  <= 1'b0;
      inj_q       <= 1'b0;
      stop_pend_q <= 1'b0;
    end else begin
      if (state_q == ST_IDLE || state_q == ST_CAL) begin
        inj_pend_q  <= 1'b0;
        stop_pend_q <= 1'b0;
      end else begin
        if (inject_req && mode[0]) begin
          inj_pend_q <= 1'b1;
        end else if (state_q == ST_GAP && gate_ok && inj_pend_q && !seq_end_q) begin
          inj_pend_q <= 1'b0;
        end
        if (stop) begin
          stop_pend_q <= 1'b1;
        end
      end
      if (state_q == ST_GAP && gate_ok && inj_pend_q && !seq_end_q && !stop_pend_q) begin
        inj_q <= 1'b1;
      end else if (state_q == ST_DONE) begin
        inj_q <= 1'b0;
      end
    end
  end

  // injected result bypasses the fifo and the main result register
  always_ff @(posedge clock or negedge rst_n_i) begin
    if (!rst_n_i) begin
      inject_result_reg <= `ADCSQ_REG_RST;
      inject_done       <= 1'b0;
    end else begin
      inject_done <= (state_q == ST_DONE) && inj_q;
      if (state_q == ST_DONE && inj_q) begin
        inject_result_reg <= `ADCSQ_REG_W'({inject_chan, 2'h0, res_q});
      end
    end
  end

  // result register, unread flag, requests
  always_ff @(posedge clock or negedge rst_n_i) begin
    if (!rst_n_i) begin
      conv_result_reg <= `ADCSQ_REG_RST;
      unread_q        <= 1'b0;
      conv_done_req   <= 1'b0;
      overrun_irq     <= 1'b0;
    end else begin
      conv_done_req <= pop;
      overrun_irq   <= pop && unread_q && !result_rd;
      if (pop) begin
        conv_result_reg <= {fout.data[DW-1 -: `ADCSQ_CHN_W], 2'h0,
                            fout.data[`ADCSQ_RES_W-1:0]};
        unread_q        <= 1'b1;
      end else if (result_rd) begin
        unread_q <= 1'b0;
      end
    end
  end

  // status and analog mux drive
  always_ff @(posedge clock or negedge rst_n_i) begin
    if (!rst_n_i) begin
      calib_busy_flag <= 1'b1;
      conv_busy       <= 1'b0;
      sample_en       <= 1'b0;
      mux_chan        <= '0;
      mux_grp         <= 1'b0;
      result_unread   <= 1'b0;
    end else begin
      calib_busy_flag <= (state_q == ST_CAL) && !cal_end;
      conv_busy       <= (state_q != ST_CAL) && (state_q != ST_IDLE);
      sample_en       <= (state_q == ST_SAMP);
      mux_grp         <= port_grp_sel;
      mux_chan        <= port_grp_sel ? {1'b0, sel_chan[2:0]} : sel_chan;
      result_unread   <= unread_q;
    end
  end

  // pins sampled as digital inputs; change taken once stages two and three agree
  always_ff @(posedge clock or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_s1_q <= '0;
      pin_s2_q <= '0;
      pin_s3_q <= '0;
      dig_pins <= '0;
    end else begin
      pin_s1_q <= ana_pins;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
      for (int i = 0; i < `ADCSQ_PIN_W; i++) begin
        if (pin_s2_q[i] == pin_s3_q[i]) begin
          dig_pins[i] <= pin_s3_q[i];
        end
      end
    end
  end
endmodule

/* bench/adcsq_ctrl_monitor.sv */
// port checker of the converter sequencer
`timescale 1ns/100ps
module adcsq_ctrl_monitor #(parameter int CAL_CYCLES = 20) (
  input wire logic                   clock,
  input wire logic                   reset_n,
  input wire logic                   start,
  input wire adcsq_pkg::adcsq_mode_e mode,
  input wire logic [7:0]             sample_time,
  input wire logic                   port_grp_sel,
  input wire logic                   hold_until_read_bit,
  input wire logic [3:0]             inject_chan,
  input wire logic                   result_rd,
  input wire logic [15:0]            conv_result_reg,
  input wire logic [15:0]            inject_result_reg,
  input wire logic                   calib_busy_flag,
  input wire logic                   conv_busy,
  input wire logic                   result_unread,
  input wire logic                   conv_done_req,
  input wire logic                   overrun_irq,
  input wire logic                   inject_done,
  input wire logic                   sample_en,
  input wire logic [3:0]             mux_chan,
  input wire logic                   mux_grp
);
  import adcsq_pkg::*;
  int cal_q;
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  // counts busy cycles since reset
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) cal_q <= 0;
    else if (calib_busy_flag) cal_q <= cal_q + 1;
  end
  sequence s_samp2; sample_en [*2] ##1 !sample_en; endsequence
  sequence s_rd_alone; result_rd ##1 !conv_done_req; endsequence
  property p_cal_len; cal_q <= CAL_CYCLES + 4; endproperty
  property p_cal_idle; calib_busy_flag |-> !conv_busy && !sample_en && !conv_done_req; endproperty
  // busy follows the state one cycle late, so a taken start shows two edges on
  property p_cal_start; calib_busy_flag && start |-> ##2 !conv_busy; endproperty
  property p_start; start && !calib_busy_flag && !conv_busy |-> ##2 conv_busy; endproperty
  property p_samp; $rose(sample_en) && sample_time == 8'h01 |-> s_samp2; endproperty
  property p_grp; sample_en |-> mux_grp == port_grp_sel && !(mux_grp && mux_chan[3]); endproperty
  property p_pulse; conv_done_req |=> !conv_done_req; endproperty
  property p_ovr; overrun_irq |-> conv_done_req; endproperty
  property p_hold; hold_until_read_bit && mode[0] |-> !overrun_irq; endproperty
  property p_inj; inject_done |-> inject_result_reg[15:12] == inject_chan
    && $stable(conv_result_reg); endproperty
  property p_rd; s_rd_alone |=> !result_unread; endproperty
  a_cal_len: assert property (p_cal_len)
    else $error("calibration too long");
  a_cal_idle: assert property (p_cal_idle)
    else $error("activity during calibration");
  a_cal_start: assert property (p_cal_start)
    else $error("start taken in calibration");
  a_start: assert property (p_start)
    else $error("start not taken");
  a_samp: assert property (p_samp)
    else $error("sample length wrong");
  a_grp: assert property (p_grp)
    else $error("group select wrong");
  a_pulse: assert property (p_pulse)
    else $error("request not a pulse");
  a_ovr: assert property (p_ovr)
    else $error("overrun without result");
  a_hold: assert property (p_hold)
    else $error("overrun in hold mode");
  a_inj: assert property (p_inj)
    else $error("injected result misplaced");
  a_rd: assert property (p_rd)
    else $error("read did not clear unread");
endmodule
bind adcsq_ctrl adcsq_ctrl_monitor #(.CAL_CYCLES(CAL_CYCLES)) u_mon (.clock, .reset_n,
  .start, .mode, .sample_time, .port_grp_sel, .hold_until_read_bit, .inject_chan,
  .result_rd, .conv_result_reg, .inject_result_reg, .calib_busy_flag, .conv_busy,
  .result_unread, .conv_done_req, .overrun_irq, .inject_done, .sample_en, .mux_chan,
  .mux_grp);

/* bench/adcsq_src_model.sv */
// analog sources seen through the input mux, and pin levels
`timescale 1ns/100ps
module adcsq_src_model (
  input  wire logic        mux_grp,
  input  wire logic [3:0]  mux_chan,
  input  wire logic [23:0] pin_lvl,
  output logic      [9:0]  ana_data,
  output logic      [23:0] ana_pins
);
  // distinct level per input, so a wrong mux shows up
  assign ana_data = {mux_grp, mux_chan, 5'h15};
  assign ana_pins = pin_lvl;
endmodule

/* bench/adcsq_ctrl_tb.sv */
// self-checking bench of the converter sequencer
`timescale 1ns/100ps
module adcsq_ctrl_tb;
  import adcsq_pkg::*;
  localparam int CAL = 20;
  logic        clock, reset_n, start, stop, port_grp_sel, hold_until_read_bit;
  logic        inject_req, result_rd, calib_busy_flag, conv_busy, result_unread;
  logic        conv_done_req, overrun_irq, inject_done, sample_en, mux_grp;
  adcsq_mode_e mode;
  logic [3:0]  chan_sel, inject_chan, mux_chan;
  logic [7:0]  sample_time, conv_time;
  logic [9:0]  ana_data;
  logic [23:0] ana_pins, pin_lvl, dig_pins;
  logic [15:0] conv_result_reg, inject_result_reg;
  int          n_errors, num_checks;
  adcsq_ctrl #(.CAL_CYCLES(CAL)) dut (.clock, .reset_n, .start, .stop, .mode, .chan_sel,
    .port_grp_sel, .hold_until_read_bit, .sample_time, .conv_time, .inject_req,
    .inject_chan, .result_rd, .ana_data, .ana_pins, .conv_result_reg, .inject_result_reg,
    .calib_busy_flag, .conv_busy, .result_unread, .conv_done_req, .overrun_irq,
    .inject_done, .sample_en, .mux_chan, .mux_grp, .dig_pins);
  adcsq_src_model u_src (.mux_grp, .mux_chan, .pin_lvl, .ana_data, .ana_pins);
  initial begin
    clock = 0;
    forever #5 clock = ~clock;
  end
  task automatic chk(input string nm, input logic [23:0] exp, input logic [23:0] got);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic report_and_stop;
    $display("errors %0d checks %0d", n_errors, num_checks);
    if (n_errors == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  function automatic logic hit(input int k);
    case (k)
      0: return !calib_busy_flag;
      1: return conv_done_req;
      2: return inject_done;
      default: return !conv_busy;
    endcase
  endfunction
  // bounded wait; a hang ends the run
  task automatic wt(input int k, input int lim, output int n);
    for (n = 0; n < lim; n++) begin
      @(negedge clock);
      if (hit(k) === 1'b1) return;
    end
    n_errors++;
    $display("ERROR wait %0d expected hit seen none", k);
    report_and_stop();
  endtask
  task automatic pulse(ref logic s);
    @(negedge clock);
    s = 1;
    @(negedge clock);
    s = 0;
  endtask
  function automatic logic [23:0] word(input logic g, input logic [3:0] c);
    return {8'h00, c, 2'b00, g, c, 5'h15};
  endfunction
  task automatic t_calib;
    int n;
    @(negedge clock);
    chk("busy_after_reset", 1, calib_busy_flag);
    pulse(start);
    wt(0, CAL + 20, n);
    chk("calib_length", CAL - 2, n);
    repeat (30) @(negedge clock);
    chk("early_start_dropped", 0, {conv_busy, result_unread});
  endtask
  task automatic t_single(input logic g, input logic [3:0] c);
    int n;
    mode = MODE_SINGLE;
    port_grp_sel = g;
    chan_sel = c;
    sample_time = 8'h01;
    conv_time = 8'h01;
    pulse(start);
    wt(1, 80, n);
    chk("single_time", 2 + 10 * 2 + 1, n);
    chk("single_result", word(g, c), conv_result_reg);
    wt(3, 20, n);
  endtask
  task automatic t_scan;
    int n, k, ov;
    pulse(result_rd);
    mode = MODE_SCAN_SINGLE;
    port_grp_sel = 0;
    chan_sel = 4'h2;
    sample_time = 0;
    conv_time = 0;
    ov = 0;
    pulse(start);
    for (k = 2; k >= 0; k--) begin
      wt(1, 60, n);
      ov += overrun_irq;
      chk("scan_result", word(0, k[3:0]), conv_result_reg);
    end
    chk("scan_overruns", 2, ov);
    wt(3, 20, n);
  endtask
  task automatic t_hold;
    int n, c;
    pulse(result_rd);
    mode = MODE_CONT;
    chan_sel = 4'h3;
    hold_until_read_bit = 1;
    pulse(start);
    wt(1, 60, n);
    c = 0;
    repeat (60) begin
      @(negedge clock);
      c += conv_done_req;
    end
    chk("held_results", 0, c);
    pulse(result_rd);
    wt(1, 40, n);
    chk("released_result", word(0, 4'h3), conv_result_reg);
    hold_until_read_bit = 0;
    pulse(stop);
    wt(3, 100, n);
  endtask
  task automatic t_inject;
    int n;
    mode = MODE_SCAN_CONT;
    chan_sel = 4'h1;
    inject_chan = 4'h6;
    pulse(start);
    wt(1, 60, n);
    pulse(inject_req);
    wt(2, 80, n);
    chk("inject_result", word(0, 4'h6), inject_result_reg);
    wt(1, 60, n);
    chk("resumed_scan", word(0, 4'h1), conv_result_reg);
    pulse(stop);
    wt(3, 100, n);
  endtask
  task automatic t_pins;
    pin_lvl = 24'hA5_C396;
    repeat (8) @(negedge clock);
    chk("dig_pins", 24'hA5_C396, dig_pins);
  endtask
  // reset while the sequencer is idle must bring calibration back
  task automatic t_rerun;
    @(negedge clock);
    reset_n = 0;
    repeat (3) @(negedge clock);
    chk("busy_in_reset", 1, calib_busy_flag);
    reset_n = 1;
    t_calib();
  endtask
  initial begin
    {start, stop, port_grp_sel, hold_until_read_bit, inject_req, result_rd} = '0;
    mode = MODE_SINGLE;
    chan_sel = 0;
    inject_chan = 0;
    sample_time = 0;
    conv_time = 0;
    pin_lvl = 0;
    n_errors = 0;
    num_checks = 0;
    reset_n = 0;
    repeat (8) @(negedge clock);
    reset_n = 1;
    t_calib();
    t_single(0, 4'hF);
    t_single(1, 4'h5);
    t_scan();
    t_hold();
    t_inject();
    t_pins();
    t_rerun();
    t_single(0, 4'h2);
    report_and_stop();
  end
endmodule
